/* File: src/crc_memory_scanner_regs.sv */
// Register file and program-memory scanner that feeds words to an external CRC engine.
// Assumes the CRC engine owns the accumulator and shifter, and a memory port answers
// each request with a one-cycle acknowledge carrying the word.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module crc_memory_scanner_regs #(
    parameter int DATA_W = 16,
    parameter logic [16:0] MEM_WORDS = scan_pkg::MEM_WORDS_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [scan_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // CRC engine
    input wire logic [15:0] crc_accum_in,
    input wire logic [15:0] crc_shift_in,
    input wire logic crc_ready,
    output logic crc_acc_wr_lo,
    output logic crc_acc_wr_hi,
    output logic [7:0] crc_acc_wr_data,
    output logic [15:0] crc_poly_terms,
    output logic [DATA_W-1:0] crc_data,
    output logic crc_data_valid,
    // Program memory fetch port
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Core side
    input wire logic irq_active,
    input wire logic cpu_free_slot,
    input wire logic [scan_pkg::TRIG_SOURCES-1:0] trig_in,
    output logic cpu_stall,
    output logic irq
);

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic acc_wr_lo;
        logic acc_wr_hi;
        logic [7:0] acc_wr_data;
        logic [15:1] poly;
        logic en;
        logic go;
        logic irq_handling_select;
        logic [1:0] mode;
        logic [3:0] trigger_source_select;
        logic [15:0] cur;
        logic [15:0] fin;
        logic [scan_pkg::IRQ_W-1:0] stat;
        logic [scan_pkg::IRQ_W-1:0] mask;
        scan_pkg::scan_state_e st;
        logic trig_pend;
        logic [DATA_W-1:0] data;
        logic data_valid;
        logic inv_prev;
    } regs_s;

    regs_s q;
    regs_s d;

    logic req;
    logic take;
    logic wr_lane;
    logic go_eff;
    logic past_end;
    logic invalid;
    logic busy;
    logic trig_sel;
    logic slot_ok;
    logic [7:0] rd_mux;
    logic [7:0] ctrl_rd;

    assign req = read | write;
    assign waitrequest = req & ~q.ack;
    assign take = req & q.ack;
    assign wr_lane = write & take & byteenable[0];

    // A request in the interrupt window is the only way go is overridden; peek ignores it.
    assign go_eff = q.go & ~(q.irq_handling_select & irq_active & (q.mode != scan_pkg::MODE_PEEK));
    assign past_end = q.cur > q.fin;
    assign invalid = {1'b0, q.cur} >= MEM_WORDS;
    assign busy = (q.st != scan_pkg::ST_IDLE) | (q.en & go_eff & crc_ready);

    // Reserved select codes match no source, so triggered mode simply waits.
    assign trig_sel = (q.trigger_source_select < 4'(scan_pkg::TRIG_SOURCES)) ? trig_in[q.trigger_source_select] : 1'b0;

    always_comb begin
        slot_ok = 1'b1;
        unique case (q.mode)
            scan_pkg::MODE_CONCURRENT: slot_ok = 1'b1;
            scan_pkg::MODE_BURST: slot_ok = 1'b1;
            scan_pkg::MODE_PEEK: slot_ok = cpu_free_slot;
            scan_pkg::MODE_TRIGGERED: slot_ok = q.trig_pend;
        endcase
    end

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[scan_pkg::CTRL_EN] = q.en;
        ctrl_rd[scan_pkg::CTRL_GO] = q.go;
        ctrl_rd[scan_pkg::CTRL_BUSY] = busy;
        ctrl_rd[scan_pkg::CTRL_INVALID] = invalid;
        ctrl_rd[scan_pkg::CTRL_IRQ_HANDLING_SELECT] = q.irq_handling_select;
        ctrl_rd[1:0] = q.mode;
    end

    always_comb begin
        rd_mux = 8'h00;
        case (address)
            scan_pkg::OFF_ACC_LO: rd_mux = crc_accum_in[7:0];
            scan_pkg::OFF_ACC_HI: rd_mux = crc_accum_in[15:8];
            scan_pkg::OFF_SHIFT_LO: rd_mux = crc_shift_in[7:0];
            scan_pkg::OFF_SHIFT_HI: rd_mux = crc_shift_in[15:8];
            scan_pkg::OFF_POLY_LO: rd_mux = {q.poly[7:1], 1'b0};
            scan_pkg::OFF_POLY_HI: rd_mux = q.poly[15:8];
            scan_pkg::OFF_CTRL: rd_mux = ctrl_rd;
            scan_pkg::OFF_CUR_LO: rd_mux = q.cur[7:0];
            scan_pkg::OFF_CUR_HI: rd_mux = q.cur[15:8];
            scan_pkg::OFF_END_LO: rd_mux = q.fin[7:0];
            scan_pkg::OFF_END_HI: rd_mux = q.fin[15:8];
            scan_pkg::OFF_TRIG: rd_mux = {4'h0, q.trigger_source_select};
            scan_pkg::OFF_IRQ_STAT: rd_mux = {6'h00, q.stat};
            scan_pkg::OFF_IRQ_MASK: rd_mux = {6'h00, q.mask};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        d = q;
        d.ack = req & ~q.ack;
        d.rdata = rd_mux;
        d.acc_wr_lo = 1'b0;
        d.acc_wr_hi = 1'b0;
        d.data_valid = 1'b0;
        d.inv_prev = invalid;

        // Register writes; address pairs are frozen while a scan is armed.
        if (wr_lane) begin
            case (address)
                scan_pkg::OFF_ACC_LO: begin
                    d.acc_wr_lo = 1'b1;
                    d.acc_wr_data = writedata[7:0];
                end
                scan_pkg::OFF_ACC_HI: begin
                    d.acc_wr_hi = 1'b1;
                    d.acc_wr_data = writedata[7:0];
                end
                scan_pkg::OFF_POLY_LO: d.poly[7:1] = writedata[7:1];
                scan_pkg::OFF_POLY_HI: d.poly[15:8] = writedata[7:0];
                scan_pkg::OFF_CTRL: begin
                    d.en = writedata[scan_pkg::CTRL_EN];
                    d.go = writedata[scan_pkg::CTRL_GO];
                    d.irq_handling_select = writedata[scan_pkg::CTRL_IRQ_HANDLING_SELECT];
                    d.mode = writedata[1:0];
                end
                scan_pkg::OFF_CUR_LO: if (!q.go) d.cur[7:0] = writedata[7:0];
                scan_pkg::OFF_CUR_HI: if (!q.go) d.cur[15:8] = writedata[7:0];
                scan_pkg::OFF_END_LO: if (!q.go) d.fin[7:0] = writedata[7:0];
                scan_pkg::OFF_END_HI: if (!q.go) d.fin[15:8] = writedata[7:0];
                scan_pkg::OFF_TRIG: d.trigger_source_select = writedata[3:0];
                scan_pkg::OFF_IRQ_MASK: d.mask = writedata[scan_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end

        // Reading the status clears it; events below are applied after, so a set wins.
        if (read && take && address == scan_pkg::OFF_IRQ_STAT) begin
            d.stat = '0;
        end

        unique case (q.st)
            scan_pkg::ST_IDLE: begin
                if (q.en && go_eff && crc_ready && slot_ok && !past_end && !invalid) begin
                    d.st = scan_pkg::ST_FETCH;
                    d.trig_pend = 1'b0;
                end
                // A scan only finishes between data cycles, never in the middle of one.
                if (q.en && q.go && (past_end || invalid)) begin
                    d.go = 1'b0;
                    d.stat[scan_pkg::IRQ_DONE] = 1'b1;
                end
            end
            scan_pkg::ST_FETCH: begin
                // The word is shown to the CRC while the address still names it.
                if (mem_ack) begin
                    d.data = mem_rdata;
                    d.data_valid = 1'b1;
                    d.st = scan_pkg::ST_DELIVER;
                end
            end
            scan_pkg::ST_DELIVER: begin
                d.cur = q.cur + 16'h0001;
                d.st = scan_pkg::ST_IDLE;
            end
        endcase

        // Applied after the fetch start, so a trigger in the consuming cycle is not lost.
        if (q.mode == scan_pkg::MODE_TRIGGERED && trig_sel) begin
            d.trig_pend = 1'b1;
        end

        if (invalid && !q.inv_prev) begin
            d.stat[scan_pkg::IRQ_INVALID] = 1'b1;
        end

        // Disabling only resets sequencing; the stored registers keep their contents.
        if (!q.en) begin
            d.st = scan_pkg::ST_IDLE;
            d.trig_pend = 1'b0;
            d.data_valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{
                ack: 1'b0,
                rdata: 8'h00,
                acc_wr_lo: 1'b0,
                acc_wr_hi: 1'b0,
                acc_wr_data: 8'h00,
                poly: scan_pkg::POLY_RESET[15:1],
                en: 1'b0,
                go: 1'b0,
                irq_handling_select: 1'b0,
                mode: scan_pkg::MODE_CONCURRENT,
                trigger_source_select: 4'h0,
                cur: scan_pkg::ADDR_RESET,
                fin: scan_pkg::ADDR_RESET,
                stat: '0,
                mask: '0,
                st: scan_pkg::ST_IDLE,
                trig_pend: 1'b0,
                data: '0,
                data_valid: 1'b0,
                inv_prev: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    assign readdata = {24'h000000, q.rdata};
    assign crc_acc_wr_lo = q.acc_wr_lo;
    assign crc_acc_wr_hi = q.acc_wr_hi;
    assign crc_acc_wr_data = q.acc_wr_data;
    assign crc_poly_terms = {q.poly, 1'b0};
    assign crc_data = q.data;
    assign crc_data_valid = q.data_valid;
    assign mem_req = (q.st == scan_pkg::ST_FETCH);
    assign mem_addr = q.cur;
    // Burst holds the core off until the range is done unless interrupts override go.
    assign cpu_stall = q.en & go_eff & (q.mode == scan_pkg::MODE_BURST);
    assign irq = |(q.stat & q.mask);

endmodule

/* File: src/scan_pkg.sv */
// Constants, register map and state encodings of the CRC memory scanner block.
// Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
// Function
// - Accumulator low byte write loads, read returns
// - Shifter bytes read-only, show live shifter value
// - Polynomial term bits 15..1, bit 0 reads zero
// - Enable clear resets scanner state machines
// - Enable clear leaves all other registers unchanged
// - Go set: fetch per mode on CRC ready
// - Hardware clears go when current exceeds end
// - Interrupt management masks go during interrupts
// - Busy while fetching, or enabled with go in effect and CRC ready
// - Invalid flag when address beyond program memory
// - Interrupt management per mode behaviour
// - Current address fetched, then incremented
// - Address writes ignored while go set
// - End address register, reset zero, compared
// - Trigger select picks event, high codes reserved
package scan_pkg;

    localparam int ADDR_W = 6;

    localparam logic [5:0] OFF_ACC_LO = 6'h00;
    localparam logic [5:0] OFF_ACC_HI = 6'h04;
    localparam logic [5:0] OFF_SHIFT_LO = 6'h08;
    localparam logic [5:0] OFF_SHIFT_HI = 6'h0c;
    localparam logic [5:0] OFF_POLY_LO = 6'h10;
    localparam logic [5:0] OFF_POLY_HI = 6'h14;
    localparam logic [5:0] OFF_CTRL = 6'h18;
    localparam logic [5:0] OFF_CUR_LO = 6'h1c;
    localparam logic [5:0] OFF_CUR_HI = 6'h20;
    localparam logic [5:0] OFF_END_LO = 6'h24;
    localparam logic [5:0] OFF_END_HI = 6'h28;
    localparam logic [5:0] OFF_TRIG = 6'h2c;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h30;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h34;

    // Control register bit positions.
    localparam int CTRL_EN = 7;
    localparam int CTRL_GO = 6;
    localparam int CTRL_BUSY = 5;
    localparam int CTRL_INVALID = 4;
    localparam int CTRL_IRQ_HANDLING_SELECT = 3;

    // Interrupt status bit positions.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_INVALID = 1;
    localparam int IRQ_W = 2;

    localparam logic [1:0] MODE_CONCURRENT = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_PEEK = 2'h2;
    localparam logic [1:0] MODE_TRIGGERED = 2'h3;

    localparam int TRIG_SOURCES = 10;
    localparam logic [16:0] MEM_WORDS_DEFAULT = 17'h04000;

    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] POLY_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_DELIVER = 3'b100
    } scan_state_e;

endpackage

/* File: verif/scan_checker.sv */
// Concurrent checks on the scanner block's ports.
// Assumes it is bound to the block and sees only those ports.
`timescale 1ns/1ps
module scan_checker (
    // Clock, reset and register bus
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // CRC engine and memory port
    input wire logic [15:0] crc_shift_in,
    input wire logic crc_ready,
    input wire logic crc_acc_wr_lo,
    input wire logic [7:0] crc_acc_wr_data,
    input wire logic [15:0] crc_poly_terms,
    input wire logic [15:0] crc_data,
    input wire logic crc_data_valid,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("Bus request waited more than one cycle.");
    a_acc_load: assert property (write && !waitrequest && byteenable[0] &&
        address == scan_pkg::OFF_ACC_LO |=> crc_acc_wr_lo &&
        crc_acc_wr_data == $past(writedata[7:0]))
        else $error("Accumulator low byte write not passed on.");
    a_shift_read: assert property (read && !waitrequest && address == scan_pkg::OFF_SHIFT_HI
        |-> readdata == {24'h000000, $past(crc_shift_in[15:8])})
        else $error("Shifter high byte read wrong.");
    a_poly_zero: assert property (!crc_poly_terms[0])
        else $error("Polynomial bit zero is set.");
    a_fetch_ready: assert property ($rose(mem_req) |-> $past(crc_ready))
        else $error("Fetch started without CRC ready.");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("Fetch request or address moved before acknowledge.");
    a_data_pass: assert property (mem_req && mem_ack |=>
        crc_data_valid && crc_data == $past(mem_rdata))
        else $error("Fetched word not handed to CRC.");
    a_valid_pulse: assert property (crc_data_valid |=> !crc_data_valid && !mem_req)
        else $error("Data valid not a single pulse.");
endmodule
bind crc_memory_scanner_regs scan_checker chk_u (
    .clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .crc_shift_in, .crc_ready, .crc_acc_wr_lo, .crc_acc_wr_data,
    .crc_poly_terms, .crc_data, .crc_data_valid, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);

/* File: verif/mem_crc_model.sv */
// Far-side model: program memory port and CRC engine values.
// Assumes the scanner holds mem_req until a one-cycle mem_ack.
`timescale 1ns/1ps
module mem_crc_model (
    // Clock, reset and scanner side
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic crc_data_valid,
    input wire logic [15:0] crc_data,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    output logic [15:0] crc_accum_in,
    output logic [15:0] crc_shift_in,
    // Tallies
    output int words,
    output int errs
);
    logic [1:0] cnt;
    assign crc_accum_in = 16'habcd;
    assign crc_shift_in = 16'h1234;
    // Every other fetch answers late, and idle read data toggles so no stale word passes.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            cnt <= 2'h0;
            words <= 0;
            errs <= 0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt <= cnt + 2'h1;
                if (cnt == (words[0] ? 2'h2 : 2'h0)) begin
                    mem_ack <= 1'b1;
                    mem_rdata <= mem_addr ^ 16'ha5a5;
                    cnt <= 2'h0;
                end
            end
            if (crc_data_valid) begin
                words <= words + 1;
                errs <= errs + int'(crc_data !== (mem_addr ^ 16'ha5a5));
            end
        end
    end
endmodule

/* File: verif/tb_crc_memory_scanner_regs.sv */
// Self-checking bench for the scanner register block.
// Assumes the checker is bound and the model answers the memory port.
`timescale 1ns/1ps
module tb_crc_memory_scanner_regs;
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, crc_ready = 1'b0;
    logic irq_active = 1'b0, cpu_free_slot = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h1;
    logic [9:0] trig_in = 10'h000;
    logic [31:0] readdata;
    logic waitrequest, crc_acc_wr_lo, crc_acc_wr_hi, crc_data_valid, mem_req, mem_ack;
    logic cpu_stall, irq;
    logic [7:0] crc_acc_wr_data;
    logic [15:0] crc_accum_in, crc_shift_in, crc_poly_terms, crc_data, mem_addr, mem_rdata;
    int words, errs, miscompares = 0, n_compared = 0;
    // A 16-word memory lets a short scan run off the end.
    crc_memory_scanner_regs #(.MEM_WORDS(17'h00010)) dut_u (
        .clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .crc_accum_in, .crc_shift_in, .crc_ready, .crc_acc_wr_lo,
        .crc_acc_wr_hi, .crc_acc_wr_data, .crc_poly_terms, .crc_data, .crc_data_valid,
        .mem_req, .mem_addr, .mem_ack, .mem_rdata, .irq_active, .cpu_free_slot,
        .trig_in, .cpu_stall, .irq);
    mem_crc_model mdl_u (.clk, .rst, .mem_req, .mem_addr, .crc_data_valid, .crc_data,
        .mem_ack, .mem_rdata, .crc_accum_in, .crc_shift_in, .words, .errs);
    always #20 clk = ~clk;
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, string nm);
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        read <= 1'b0;
        if (!wr) chk(nm, d, readdata[7:0]);
    endtask
    task automatic wait_words(input int n);
        for (int i = 0; i < 300 && words < n; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("words", 8'(n), 8'(words));
    endtask
    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, scan_pkg::OFF_CTRL, 8'h00, "ctrl");
        bus(0, scan_pkg::OFF_END_HI, 8'h00, "end_hi");
        bus(1, scan_pkg::OFF_SHIFT_LO, 8'hff, "");
        bus(0, scan_pkg::OFF_SHIFT_LO, 8'h34, "shift_lo");
        bus(0, scan_pkg::OFF_SHIFT_HI, 8'h12, "shift_hi");
        bus(1, scan_pkg::OFF_ACC_LO, 8'h5a, "");
        bus(0, scan_pkg::OFF_ACC_LO, 8'hcd, "acc_lo");
        bus(1, scan_pkg::OFF_POLY_LO, 8'hff, "");
        bus(0, scan_pkg::OFF_POLY_LO, 8'hfe, "poly_lo");
        bus(0, 6'h3c, 8'h00, "unmapped");
        bus(1, scan_pkg::OFF_IRQ_MASK, 8'h03, "");
        bus(1, scan_pkg::OFF_CUR_LO, 8'h02, "");
        bus(1, scan_pkg::OFF_END_LO, 8'h03, "");
        bus(1, scan_pkg::OFF_CTRL, 8'hc0, "");
        bus(1, scan_pkg::OFF_CUR_LO, 8'h09, "");
        bus(0, scan_pkg::OFF_CUR_LO, 8'h02, "cur_lo");
        bus(0, scan_pkg::OFF_CTRL, 8'hc0, "ctrl");
        bus(1, scan_pkg::OFF_CTRL, 8'h40, "");
        bus(0, scan_pkg::OFF_CTRL, 8'h40, "ctrl");
        bus(1, scan_pkg::OFF_CTRL, 8'hc0, "");
        crc_ready <= 1'b1;
        wait_words(2);
        bus(0, scan_pkg::OFF_CTRL, 8'h80, "ctrl");
        bus(0, scan_pkg::OFF_CUR_LO, 8'h04, "cur_lo");
        chk("irq", 8'h01, {7'h00, irq});
        bus(0, scan_pkg::OFF_IRQ_STAT, 8'h01, "irq_stat");
        repeat (2) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        chk("errs", 8'h00, 8'(errs));
        bus(1, scan_pkg::OFF_CUR_LO, 8'h0f, "");
        bus(1, scan_pkg::OFF_END_LO, 8'h0f, "");
        bus(1, scan_pkg::OFF_CTRL, 8'hc0, "");
        wait_words(3);
        bus(0, scan_pkg::OFF_CTRL, 8'h90, "ctrl");
        bus(0, scan_pkg::OFF_CUR_LO, 8'h10, "cur_lo");
        bus(0, scan_pkg::OFF_IRQ_STAT, 8'h03, "irq_stat");
        // Burst held off by an interrupt keeps go stored and does not stall the core.
        irq_active <= 1'b1;
        bus(1, scan_pkg::OFF_CUR_LO, 8'h04, "");
        bus(1, scan_pkg::OFF_END_LO, 8'h05, "");
        bus(1, scan_pkg::OFF_CTRL, 8'hc9, "");
        wait_words(3);
        chk("stall", 8'h00, {7'h00, cpu_stall});
        bus(0, scan_pkg::OFF_CTRL, 8'hc9, "ctrl");
        irq_active <= 1'b0;
        @(posedge clk);
        chk("stall", 8'h01, {7'h00, cpu_stall});
        wait_words(5);
        chk("stall", 8'h00, {7'h00, cpu_stall});
        // Peek waits for a free slot and ignores interrupt management.
        irq_active <= 1'b1;
        bus(1, scan_pkg::OFF_CUR_LO, 8'h06, "");
        bus(1, scan_pkg::OFF_END_LO, 8'h06, "");
        bus(1, scan_pkg::OFF_CTRL, 8'hca, "");
        wait_words(5);
        bus(0, scan_pkg::OFF_CTRL, 8'hea, "ctrl");
        cpu_free_slot <= 1'b1;
        wait_words(6);
        irq_active <= 1'b0;
        cpu_free_slot <= 1'b0;
        // Reserved select codes never start a transfer; a valid select does.
        bus(1, scan_pkg::OFF_CUR_LO, 8'h07, "");
        bus(1, scan_pkg::OFF_END_LO, 8'h07, "");
        bus(1, scan_pkg::OFF_TRIG, 8'h0a, "");
        bus(1, scan_pkg::OFF_CTRL, 8'hc3, "");
        trig_in <= 10'h3ff;
        wait_words(6);
        trig_in <= 10'h000;
        bus(1, scan_pkg::OFF_TRIG, 8'h02, "");
        bus(0, scan_pkg::OFF_TRIG, 8'h02, "trig");
        trig_in <= 10'h004;
        @(posedge clk);
        trig_in <= 10'h000;
        wait_words(7);
        complete_run();
    end
endmodule
